// file: src/dpm_bank.sv
// de-pop, dac start-up and pin one configuration bank with wishbone access
//
// How it works
// - Depop bits 7:4 pick the headphone series resistor, reset code 5.
// - Depop bits 3:0 pick the charging time 2ms..5s, reset code 5.
// - Misc bit 7 adds a capacitor discharge phase to dac start-up.
// - Misc bit 6 delays dac power-up by the selected interval.
// - Misc bit 5 picks a 64ms (0) or 256ms (1) power-up delay.
// - Misc bit 4 enables hard reset after 2ms without the selected clock.
// - Pin bits 7:4 pick the pin function, reset code 3.
// - Function codes 5..13 route serial port signals, 14 and 15 reserved.
// - Pin bits 2:0 pick the drive style, reset code 2.
// - Drive style is ignored when a serial data output is selected.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module dpm_bank #(
  parameter int TICK_CYC = dpm_pkg::MS_CYC,
  parameter int LOSS_CYC = dpm_pkg::LOSS_MS * dpm_pkg::MS_CYC,
  parameter int DISCH_MS = dpm_pkg::DISCH_MS
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [5:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // dac start-up and clock watch
  input wire logic DAC_PWR_REQ,
  input wire logic SEL_CLK,
  output logic DAC_DISCHARGE,
  output logic HP_CHARGING,
  output logic DAC_PWR_ON,
  output logic HARD_RST_OUT,
  output logic [3:0] HP_RSER_SEL,
  // pin one sources
  input wire logic GPO_VAL,
  input wire logic IRQ_SRC,
  input wire logic PDM_CLK_SRC,
  input wire logic [8:0] SER_SRC,
  // pin one pad
  input wire logic PIN_I,
  output logic PIN_O,
  output logic PIN_OE,
  output logic PIN_PU,
  output logic PIN_PD
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
  localparam int MW = dpm_pkg::MS_W;

  if (TICK_CYC < 1 || DISCH_MS < 1 || DISCH_MS > 5000) begin : g_chk
    $error("dpm_bank: TICK_CYC or DISCH_MS out of range");
  end

  logic [7:0] depop_r;
  logic [7:0] misc_r;
  logic [7:0] pin_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] rd_nxt;
  logic bus_req;
  logic [3:0] idx;
  logic [TW-1:0] div_r;
  logic tick;
  logic [MW-1:0] ms_r;
  logic [MW-1:0] chg_ms;
  logic [MW-1:0] dly_ms;
  dpm_pkg::dpm_state_t st_r;
  dpm_pkg::dpm_state_t st_nxt;
  logic [MW-1:0] ms_nxt;
  logic gpi_r;
  logic hard_r;
  logic pin_o_nxt, pin_oe_nxt, pin_pu_nxt, pin_pd_nxt;
  dpm_pkg::dpm_func_t func;
  dpm_pkg::dpm_drv_t drv;

  dpm_loss_if loss ();

  assign bus_req = CYC_I && STB_I && !ack_r;
  assign idx = ADR_I[5:dpm_pkg::ADR_LSB];
  assign func = dpm_pkg::dpm_func_t'(pin_r[dpm_pkg::F_FUNC_LSB +: 4]);
  assign drv = dpm_pkg::dpm_drv_t'(pin_r[dpm_pkg::F_DRV_LSB +: 3]);

  // register writes on the low byte lane
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      depop_r <= dpm_pkg::RST_DEPOP;
      misc_r <= dpm_pkg::RST_MISC;
      pin_r <= dpm_pkg::RST_PIN;
    end else if (bus_req && WE_I && SEL_I[0]) begin
      if (idx == dpm_pkg::IDX_DEPOP) begin
        depop_r <= DAT_I[7:0];
      end else if (idx == dpm_pkg::IDX_MISC) begin
        misc_r <= DAT_I[7:0] & dpm_pkg::WMASK_MISC;
      end else if (idx == dpm_pkg::IDX_PIN) begin
        pin_r <= DAT_I[7:0] & dpm_pkg::WMASK_PIN;
      end
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    if (idx == dpm_pkg::IDX_DEPOP) begin
      rd_nxt = depop_r;
    end else if (idx == dpm_pkg::IDX_MISC) begin
      rd_nxt = misc_r;
    end else if (idx == dpm_pkg::IDX_PIN) begin
      rd_nxt = pin_r;
    end else if (idx == dpm_pkg::IDX_STATUS) begin
      rd_nxt = {hard_r, gpi_r, 1'b0, st_r};
    end else begin
      rd_nxt = 8'h00;
    end
  end

  // one-cycle acknowledge with registered read data
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !WE_I) begin
        dat_r <= {24'h000000, rd_nxt};
      end
    end
  end

  // millisecond tick divider
  always_ff @(posedge MCLK) begin
    if (!NRST || st_r == dpm_pkg::ST_IDLE || div_r == TICK_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + TW'(1);
    end
  end
  assign tick = div_r == TICK_LAST;

  // charging time in ms; reserved codes take the longest
  always_comb begin
    case (depop_r[dpm_pkg::F_CHG_LSB +: 4])
      4'h0: chg_ms = MW'(2);
      4'h1: chg_ms = MW'(4);
      4'h2: chg_ms = MW'(8);
      4'h3: chg_ms = MW'(16);
      4'h4: chg_ms = MW'(50);
      4'h5: chg_ms = MW'(100);
      4'h6: chg_ms = MW'(250);
      4'h7: chg_ms = MW'(500);
      4'h8: chg_ms = MW'(1000);
      default: chg_ms = MW'(5000);
    endcase
  end

  // power-up delay length
  assign dly_ms = misc_r[dpm_pkg::F_DLY_LEN] ?
    MW'(dpm_pkg::DLY_LONG_MS) : MW'(dpm_pkg::DLY_SHORT_MS);

  // dac start-up sequencer next state
  always_comb begin
    st_nxt = st_r;
    ms_nxt = ms_r;
    if (tick && ms_r != '0) begin
      ms_nxt = ms_r - MW'(1);
    end
    case (st_r)
      dpm_pkg::ST_IDLE: begin
        if (DAC_PWR_REQ) begin
          if (misc_r[dpm_pkg::F_DISCH]) begin
            st_nxt = dpm_pkg::ST_DISCH;
            ms_nxt = MW'(DISCH_MS);
          end else if (misc_r[dpm_pkg::F_DLY_EN]) begin
            st_nxt = dpm_pkg::ST_DELAY;
            ms_nxt = dly_ms;
          end else begin
            st_nxt = dpm_pkg::ST_CHARGE;
            ms_nxt = chg_ms;
          end
        end
      end
      dpm_pkg::ST_DISCH: begin
        if (tick && ms_r == MW'(1)) begin
          if (misc_r[dpm_pkg::F_DLY_EN]) begin
            st_nxt = dpm_pkg::ST_DELAY;
            ms_nxt = dly_ms;
          end else begin
            st_nxt = dpm_pkg::ST_CHARGE;
            ms_nxt = chg_ms;
          end
        end
      end
      dpm_pkg::ST_DELAY: begin
        if (tick && ms_r == MW'(1)) begin
          st_nxt = dpm_pkg::ST_CHARGE;
          ms_nxt = chg_ms;
        end
      end
      dpm_pkg::ST_CHARGE: begin
        if (tick && ms_r == MW'(1)) begin
          st_nxt = dpm_pkg::ST_ON;
        end
      end
      dpm_pkg::ST_ON: begin
        st_nxt = dpm_pkg::ST_ON;
      end
      default: begin
        st_nxt = dpm_pkg::ST_IDLE;
      end
    endcase
    if (!DAC_PWR_REQ || hard_r) begin
      st_nxt = dpm_pkg::ST_IDLE;
      ms_nxt = '0;
    end
  end

  // sequencer state and outputs
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      st_r <= dpm_pkg::ST_IDLE;
      ms_r <= '0;
      DAC_DISCHARGE <= 1'b0;
      HP_CHARGING <= 1'b0;
      DAC_PWR_ON <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ms_r <= ms_nxt;
      DAC_DISCHARGE <= st_nxt == dpm_pkg::ST_DISCH;
      HP_CHARGING <= st_nxt == dpm_pkg::ST_CHARGE;
      DAC_PWR_ON <= st_nxt == dpm_pkg::ST_ON;
    end
  end

  // resistor select follows the register
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      HP_RSER_SEL <= dpm_pkg::RST_DEPOP[dpm_pkg::F_RSER_LSB +: 4];
    end else begin
      HP_RSER_SEL <= depop_r[dpm_pkg::F_RSER_LSB +: 4];
    end
  end

  // clock watchdog
  assign loss.enable = misc_r[dpm_pkg::F_LOSS_EN];
  assign loss.clk_level = SEL_CLK;
  dpm_clk_watch #(
    .LOSS_CYC(LOSS_CYC)
  ) u_watch (
    .MCLK(MCLK),
    .NRST(NRST),
    .lnk(loss.mon)
  );

  // hard reset output
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      hard_r <= 1'b0;
      HARD_RST_OUT <= 1'b0;
    end else begin
      hard_r <= loss.lost;
      HARD_RST_OUT <= loss.lost;
    end
  end

  // pin value and drive style
  always_comb begin
    pin_o_nxt = 1'b0;
    pin_oe_nxt = 1'b0;
    pin_pu_nxt = 1'b0;
    pin_pd_nxt = 1'b0;
    case (func)
      dpm_pkg::FN_GPO: pin_o_nxt = GPO_VAL;
      dpm_pkg::FN_IRQ: pin_o_nxt = IRQ_SRC;
      dpm_pkg::FN_PDM: pin_o_nxt = PDM_CLK_SRC;
      dpm_pkg::FN_P_DOUT: pin_o_nxt = SER_SRC[0];
      dpm_pkg::FN_P_DOUT2: pin_o_nxt = SER_SRC[1];
      dpm_pkg::FN_S_DOUT: pin_o_nxt = SER_SRC[2];
      dpm_pkg::FN_S_DOUT2: pin_o_nxt = SER_SRC[3];
      dpm_pkg::FN_S_BCLK: pin_o_nxt = SER_SRC[4];
      dpm_pkg::FN_S_FSYNC: pin_o_nxt = SER_SRC[5];
      dpm_pkg::FN_CLKOUT: pin_o_nxt = SER_SRC[6];
      dpm_pkg::FN_MUX_DOUT: pin_o_nxt = SER_SRC[7];
      dpm_pkg::FN_DAISY: pin_o_nxt = SER_SRC[8];
      default: pin_o_nxt = 1'b0;
    endcase
    if (func == dpm_pkg::FN_P_DOUT || func == dpm_pkg::FN_P_DOUT2 ||
        func == dpm_pkg::FN_S_DOUT || func == dpm_pkg::FN_S_DOUT2 ||
        func == dpm_pkg::FN_MUX_DOUT || func == dpm_pkg::FN_DAISY) begin
      pin_oe_nxt = 1'b1;
    end else if (func >= dpm_pkg::FN_GPO && func <= dpm_pkg::FN_DAISY) begin
      case (drv)
        dpm_pkg::DRV_PUSH: pin_oe_nxt = 1'b1;
        dpm_pkg::DRV_LOW_WEAKH: begin
          pin_oe_nxt = !pin_o_nxt;
          pin_pu_nxt = pin_o_nxt;
        end
        dpm_pkg::DRV_LOW_ONLY: pin_oe_nxt = !pin_o_nxt;
        dpm_pkg::DRV_WEAKL_HIGH: begin
          pin_oe_nxt = pin_o_nxt;
          pin_pd_nxt = !pin_o_nxt;
        end
        dpm_pkg::DRV_HIGH_ONLY: pin_oe_nxt = pin_o_nxt;
        default: pin_oe_nxt = 1'b0;
      endcase
    end
  end

  // pad registers and input capture
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      PIN_O <= 1'b0;
      PIN_OE <= 1'b0;
      PIN_PU <= 1'b0;
      PIN_PD <= 1'b0;
      gpi_r <= 1'b0;
    end else begin
      PIN_O <= pin_o_nxt;
      PIN_OE <= pin_oe_nxt;
      PIN_PU <= pin_pu_nxt;
      PIN_PD <= pin_pd_nxt;
      gpi_r <= func == dpm_pkg::FN_GPI ? PIN_I : 1'b0;
    end
  end

  assign DAT_O = dat_r;
  assign ACK_O = ack_r;
endmodule : dpm_bank

// file: src/dpm_clk_watch.sv
// watchdog that flags a selected clock absent for a whole interval
`timescale 1ns/1ps
module dpm_clk_watch #(
  parameter int LOSS_CYC = dpm_pkg::LOSS_MS * dpm_pkg::MS_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // watched clock and verdict
  dpm_loss_if.mon lnk
);
  localparam int CW = $clog2(LOSS_CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(LOSS_CYC);

  if (LOSS_CYC < 2) begin : g_chk
    $error("dpm_clk_watch: LOSS_CYC must be at least 2");
  end

  logic prev_r;
  logic [CW-1:0] cnt_r;
  logic lost_r;
  logic edge_seen;

  assign edge_seen = lnk.clk_level != prev_r;

  // previous level for edge detection
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= lnk.clk_level;
    end
  end

  // absence counter, restarted by any edge
  always_ff @(posedge MCLK) begin
    if (!NRST || !lnk.enable || edge_seen) begin
      cnt_r <= '0;
    end else if (cnt_r != LIMIT) begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // verdict holds while the absence lasts
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      lost_r <= 1'b0;
    end else begin
      lost_r <= lnk.enable && !edge_seen && cnt_r == LIMIT;
    end
  end

  assign lnk.lost = lost_r;
endmodule : dpm_clk_watch

// file: src/dpm_loss_if.sv
// link between the bank and its clock-loss watchdog
`timescale 1ns/1ps
interface dpm_loss_if;
  logic enable;
  logic clk_level;
  logic lost;
  modport ctrl (output enable, output clk_level, input lost);
  modport mon (input enable, input clk_level, output lost);
endinterface : dpm_loss_if

// file: src/dpm_pkg.sv
// constants for the de-pop, dac start-up and pin one configuration bank
package dpm_pkg;
  // clock rate and derived millisecond count
  localparam int CLK_HZ = 125000000;
  localparam int MS_CYC = CLK_HZ / 1000;
  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_DEPOP = 4'h6;
  localparam logic [3:0] IDX_MISC = 4'h7;
  localparam logic [3:0] IDX_PIN = 4'hA;
  localparam logic [3:0] IDX_STATUS = 4'hF;
  localparam int ADR_LSB = 2;
  // reset values
  localparam logic [7:0] RST_DEPOP = 8'h55;
  localparam logic [7:0] RST_MISC = 8'h00;
  localparam logic [7:0] RST_PIN = 8'h32;
  // field positions
  localparam int F_RSER_LSB = 4;
  localparam int F_CHG_LSB = 0;
  localparam int F_DISCH = 7;
  localparam int F_DLY_EN = 6;
  localparam int F_DLY_LEN = 5;
  localparam int F_LOSS_EN = 4;
  localparam int F_FUNC_LSB = 4;
  localparam int F_DRV_LSB = 0;
  // writable masks; reserved bits stay zero
  localparam logic [7:0] WMASK_MISC = 8'hF0;
  localparam logic [7:0] WMASK_PIN = 8'hF7;
  // times in milliseconds and the millisecond counter width
  localparam int LOSS_MS = 2;
  localparam int DLY_SHORT_MS = 64;
  localparam int DLY_LONG_MS = 256;
  localparam int DISCH_MS = 10;
  localparam int MS_W = 13;
  // pin function codes
  typedef enum logic [3:0] {
    FN_OFF = 4'h0, FN_GPI = 4'h1, FN_GPO = 4'h2, FN_IRQ = 4'h3,
    FN_PDM = 4'h4, FN_P_DOUT = 4'h5, FN_P_DOUT2 = 4'h6,
    FN_S_DOUT = 4'h7, FN_S_DOUT2 = 4'h8, FN_S_BCLK = 4'h9,
    FN_S_FSYNC = 4'hA, FN_CLKOUT = 4'hB, FN_MUX_DOUT = 4'hC,
    FN_DAISY = 4'hD
  } dpm_func_t;
  // drive style codes
  typedef enum logic [2:0] {
    DRV_HIZ = 3'h0, DRV_PUSH = 3'h1, DRV_LOW_WEAKH = 3'h2,
    DRV_LOW_ONLY = 3'h3, DRV_WEAKL_HIGH = 3'h4, DRV_HIGH_ONLY = 3'h5
  } dpm_drv_t;
  // dac start-up sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_DISCH = 5'h02, ST_DELAY = 5'h04,
    ST_CHARGE = 5'h08, ST_ON = 5'h10
  } dpm_state_t;
endpackage : dpm_pkg

// file: tb/dpm_bank_bench.sv
// random and corner tests of the configuration bank
`timescale 1ns/1ps
module dpm_bank_bench;
  localparam int TICK = 10;
  localparam int LOSS = 50;
  localparam int DISCH = 10;
  localparam int CHG_MS [10] = '{2, 4, 8, 16, 50, 100, 250, 500, 1000, 5000};
  localparam logic [3:0] IDXS [3] = '{4'h6, 4'h7, 4'hA};
  localparam logic [7:0] RSTV [3] = '{8'h55, 8'h00, 8'h32};
  localparam logic [7:0] MISCS [5] = '{8'h00, 8'h80, 8'h40, 8'h60, 8'hE0};
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic req = 1'b0;
  logic sclk = 1'b0;
  logic [11:0] src = 12'h000;
  logic pin_i = 1'b0;
  logic [31:0] rdat;
  logic ack, disch, chg, pon, hrst, poe, po, ppu, ppd;
  logic [3:0] rser;
  logic [7:0] q;
  int failures = 0;
  int num_checks = 0;
  int seed = 28785;
  // clock
  always #4 mclk = ~mclk;
  dpm_bank #(.TICK_CYC(TICK), .LOSS_CYC(LOSS), .DISCH_MS(DISCH)) u_dpm_bank (
    .MCLK(mclk), .NRST(nrst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .DAC_PWR_REQ(req), .SEL_CLK(sclk), .DAC_DISCHARGE(disch),
    .HP_CHARGING(chg), .DAC_PWR_ON(pon), .HARD_RST_OUT(hrst),
    .HP_RSER_SEL(rser), .GPO_VAL(src[9]), .IRQ_SRC(src[10]),
    .PDM_CLK_SRC(src[11]), .SER_SRC(src[8:0]), .PIN_I(pin_i),
    .PIN_O(po), .PIN_OE(poe), .PIN_PU(ppu), .PIN_PD(ppd));
  // comparisons
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_time(input int got, input int exp);
    num_checks++;
    if (got < exp - 3 || got > exp + 4) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk_time
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // one classic bus cycle; only the watchdog ends a missing ack
  task automatic wb(input logic w, input logic [3:0] idx,
    input logic [7:0] d, output logic [7:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    @(posedge mclk);
    while (ack !== 1'b1) begin
      @(posedge mclk);
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
  endtask : wb
  // expected values
  function automatic logic [7:0] wmask(input logic [3:0] idx);
    case (idx)
      dpm_pkg::IDX_DEPOP: return 8'hFF;
      dpm_pkg::IDX_MISC: return 8'hF0;
      dpm_pkg::IDX_PIN: return 8'hF7;
      default: return 8'h00;
    endcase
  endfunction : wmask
  function automatic int seq_len(input logic [7:0] m, input logic [3:0] c);
    return (m[7] ? DISCH : 0) + (m[6] ? (m[5] ? 256 : 64) : 0) + CHG_MS[c];
  endfunction : seq_len
  // pad as {drive, driven value, pull-up, pull-down}
  function automatic logic [3:0] exp_pad(input logic [3:0] f,
    input logic [2:0] dv, input logic [11:0] s);
    logic v;
    if (f < 4'h2 || f > 4'hD) return 4'h0;
    v = (f >= 4'h5) ? s[f - 4'h5] : s[f + 4'h7];
    if (f inside {4'h5, 4'h6, 4'h7, 4'h8, 4'hC, 4'hD}) return {1'h1, v, 2'h0};
    case (dv)
      3'h1: return {1'h1, v, 2'h0};
      3'h2: return v ? 4'h2 : 4'h8;
      3'h3: return v ? 4'h0 : 4'h8;
      3'h4: return v ? 4'hC : 4'h1;
      3'h5: return v ? 4'hC : 4'h0;
      default: return 4'h0;
    endcase
  endfunction : exp_pad
  // main sequence
  initial begin
    logic [7:0] d;
    logic [3:0] idx;
    logic [3:0] pad;
    int n, nd, nc, seen;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      wb(1'b0, IDXS[i], 8'h00, q);
      chk_val(q, RSTV[i]);
    end
    chk_val(rser, 4'h5);
    for (int i = 0; i < 24; i++) begin
      idx = (i % 4 == 3) ? 4'h3 : IDXS[i % 3];
      d = 8'($random(seed));
      if (wmask(idx) != 8'h00) d = d & wmask(idx);
      wb(1'b1, idx, d, q);
      wb(1'b0, idx, 8'h00, q);
      chk_val(q, d & wmask(idx));
    end
    wb(1'b1, 4'h6, 8'h9A, q);
    sel <= 4'hE;
    wb(1'b1, 4'h6, 8'h17, q);
    sel <= 4'hF;
    wb(1'b0, 4'h6, 8'h00, q);
    chk_val(q, 8'h9A);
    chk_val(rser, 4'h9);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      idx = 4'(i);
      wb(1'b1, 4'h6, {4'h5, idx}, q);
      wb(1'b1, 4'h7, MISCS[i], q);
      req <= 1'b1;
      n = 0;
      nd = 0;
      nc = 0;
      while (pon !== 1'b1 && n < 9000) begin
        @(posedge mclk);
        n++;
        if (disch === 1'b1) nd++;
        if (chg === 1'b1) nc++;
      end
      chk_time(nd, MISCS[i][7] ? DISCH * TICK : 0);
      chk_time(nc, CHG_MS[idx] * TICK);
      chk_time(n, seq_len(MISCS[i], idx) * TICK);
      req <= 1'b0;
      repeat (4) @(posedge mclk);
      chk_val(pon, 1'b0);
    end
    $display("start-up test done");
    wb(1'b1, 4'h7, 8'h10, q);
    seen = 0;
    for (int i = 1; i <= 200; i++) begin
      @(posedge mclk);
      if (i % 4 == 0) sclk <= ~sclk;
      if (i > 12 && hrst !== 1'b0) seen++;
    end
    chk_val(seen, 0);
    n = 0;
    while (hrst !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk_time(n, LOSS + 4);
    sclk <= ~sclk;
    repeat (4) @(posedge mclk);
    chk_val(hrst, 1'b0);
    wb(1'b1, 4'h7, 8'h00, q);
    repeat (100) @(posedge mclk);
    chk_val(hrst, 1'b0);
    $display("clock loss test done");
    for (int i = 0; i < 32; i++) begin
      idx = i[4:1];
      d = {idx, 1'h0, 3'($random(seed))};
      wb(1'b1, 4'hA, d, q);
      src <= 12'($random(seed));
      pin_i <= 1'($random(seed));
      repeat (3) @(posedge mclk);
      pad = {poe, poe & po, ~poe & ppu, ~poe & ppd};
      chk_val(pad, exp_pad(idx, d[2:0], src));
      wb(1'b0, 4'hF, 8'h00, q);
      chk_val(q, {1'b0, idx == 4'h1 && pin_i, 6'h01});
    end
    $display("pin test done");
    final_report();
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    final_report();
  end
endmodule : dpm_bank_bench

// file: tb/dpm_bank_monitor.sv
// port checker for the configuration bank
`timescale 1ns/1ps
module dpm_bank_monitor #(
  parameter int LOSS_CYC = dpm_pkg::LOSS_MS * dpm_pkg::MS_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic NRST,
  // wishbone
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [5:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic ACK_O,
  // sequencer and clock watch
  input wire logic SEL_CLK,
  input wire logic DAC_DISCHARGE,
  input wire logic HP_CHARGING,
  input wire logic DAC_PWR_ON,
  input wire logic HARD_RST_OUT,
  input wire logic [3:0] HP_RSER_SEL
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);
  logic req_w;
  logic prev_r;
  logic [31:0] quiet_r;
  logic [3:0] rser_r;
  assign req_w = CYC_I && STB_I && !ACK_O;
  // cycles since the watched clock last moved
  always_ff @(posedge MCLK) begin
    prev_r <= SEL_CLK;
    if (!NRST || SEL_CLK != prev_r) begin
      quiet_r <= 32'h00000000;
    end else if (quiet_r != 32'hFFFFFFFF) begin
      quiet_r <= quiet_r + 32'h00000001;
    end
  end
  // resistor code last accepted on the bus
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      rser_r <= 4'h5;
    end else if (req_w && WE_I && SEL_I[0]
                 && ADR_I[5:2] == dpm_pkg::IDX_DEPOP) begin
      rser_r <= DAT_I[7:4];
    end
  end
  chk_ack_answer: assert property (req_w |=> ACK_O)
    else $error("ack missing");
  chk_ack_single: assert property (ACK_O |=> !ACK_O)
    else $error("ack too long");
  chk_rser_mirror: assert property (
    !req_w && !ACK_O && !$past(ACK_O) |-> HP_RSER_SEL == rser_r)
    else $error("resistor select stale");
  chk_rser_reset: assert property (
    $rose(NRST) |-> HP_RSER_SEL == 4'h5)
    else $error("resistor reset code");
  chk_phase_onehot: assert property (
    $onehot0({DAC_DISCHARGE, HP_CHARGING, DAC_PWR_ON}))
    else $error("phases overlap");
  chk_on_after_charge: assert property (
    $rose(DAC_PWR_ON) |-> $past(HP_CHARGING))
    else $error("power on without charge");
  chk_loss_min: assert property (
    $rose(HARD_RST_OUT) |-> quiet_r >= LOSS_CYC)
    else $error("hard reset too early");
  chk_loss_clear: assert property (
    $changed(SEL_CLK) |-> ##[1:3] !HARD_RST_OUT)
    else $error("hard reset held");
  chk_hrst_idles: assert property (
    HARD_RST_OUT [*3] |-> !DAC_PWR_ON)
    else $error("power on in hard reset");
  cov_write: cover property (ACK_O && WE_I);
  cov_power: cover property ($rose(DAC_PWR_ON));
  cov_loss: cover property ($rose(HARD_RST_OUT));
endmodule : dpm_bank_monitor
bind dpm_bank dpm_bank_monitor #(.LOSS_CYC(LOSS_CYC)) u_dpm_bank_monitor (
  .MCLK(MCLK),
  .NRST(NRST),
  .CYC_I(CYC_I),
  .STB_I(STB_I),
  .WE_I(WE_I),
  .ADR_I(ADR_I),
  .SEL_I(SEL_I),
  .DAT_I(DAT_I),
  .ACK_O(ACK_O),
  .SEL_CLK(SEL_CLK),
  .DAC_DISCHARGE(DAC_DISCHARGE),
  .HP_CHARGING(HP_CHARGING),
  .DAC_PWR_ON(DAC_PWR_ON),
  .HARD_RST_OUT(HARD_RST_OUT),
  .HP_RSER_SEL(HP_RSER_SEL)
);
